// file: core/prre_pkg.sv
// Shared constants and types for the page request report block
package prre_pkg;
	// Descriptor layout, 128 bits, type code in the lowest two bits
	localparam int DESC_W = 128;
	localparam int TYPE_LSB = 0;
	localparam logic [1:0] TYPE_PAGE_REQ = 2'h1;
	localparam int POS_STREAM_REPLY = 2;
	localparam int POS_BLOCKED = 3;
	localparam int POS_PASID_PRESENT = 8;
	localparam int POS_BUS = 16;
	localparam int POS_DEVFN = 24;
	localparam int POS_PASID = 32;
	localparam int POS_RD = 52;
	localparam int POS_WR = 53;
	localparam int POS_LAST = 54;
	localparam int POS_PRIV = 55;
	localparam int POS_DATA = 56;
	localparam int POS_GROUP = 64;
	localparam int POS_EXEC = 73;
	localparam int POS_ADDR = 76;
	localparam int SRC_W = 16;
	localparam int BUS_W = 8;
	localparam int PASID_W = 20;
	localparam int ADDR_W = 52;
	localparam int GROUP_W = 9;
	localparam int DATA_W = 8;
	// Queue entry is 16 bytes
	localparam int ENTRY_SHIFT = 4;

	// Register byte offsets
	localparam logic [7:0] REG_BASE = 8'h00;
	localparam logic [7:0] REG_HEAD = 8'h04;
	localparam logic [7:0] REG_TAIL = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_EVENT = 8'h10;
	localparam int STATUS_PENDING_BIT = 0;
	localparam int EVENT_MASK_BIT = 31;
	localparam int EVENT_HELD_BIT = 30;
	localparam logic MASK_RESET = 1'h1;
	localparam logic [31:0] BASE_RESET = 32'h0000_0000;

	typedef struct packed {
		logic [SRC_W-1:0] source_id;
		logic pasid_present;
		logic [PASID_W-1:0] pasid;
		logic [ADDR_W-1:0] page_addr;
		logic [GROUP_W-1:0] group_index;
		logic last_in_group;
		logic stream_reply_wanted;
		logic blocked_on_fault_flag;
		logic read_req;
		logic write_req;
		logic exec_req;
		logic priv_req;
		logic [DATA_W-1:0] private_data;
	} prre_req_type;

	typedef enum logic [0:0] {
		PRRE_IDLE = 1'b0,
		PRRE_WRITE = 1'b1
	} prre_phase_type;
endpackage : prre_pkg

// file: core/prre_desc_format.sv
// Builds a page request descriptor from an incoming message
`timescale 1ns/1ps
module prre_desc_format (
	input wire prre_pkg::prre_req_type req_in,
	output logic [prre_pkg::DESC_W-1:0] desc_out
);
	logic has_access;
	logic stream_ok;

	always_comb begin
		has_access = req_in.read_req | req_in.write_req;
		stream_ok = req_in.stream_reply_wanted & ~req_in.last_in_group;
		desc_out = '0;
		desc_out[prre_pkg::TYPE_LSB +: 2] = prre_pkg::TYPE_PAGE_REQ; // R1 R25
		desc_out[prre_pkg::POS_BUS +: prre_pkg::BUS_W] = req_in.source_id[15:8]; // R3
		desc_out[prre_pkg::POS_DEVFN +: prre_pkg::BUS_W] = req_in.source_id[7:0]; // R3
		desc_out[prre_pkg::POS_PASID_PRESENT] = req_in.pasid_present; // R4
		// Undefined fields are written as zero so nothing leaks
		if (req_in.pasid_present) begin
			desc_out[prre_pkg::POS_PASID +: prre_pkg::PASID_W] = req_in.pasid; // R4
		end
		if (has_access) begin
			desc_out[prre_pkg::POS_ADDR +: prre_pkg::ADDR_W] = req_in.page_addr; // R5
			desc_out[prre_pkg::POS_GROUP +: prre_pkg::GROUP_W] = req_in.group_index; // R6
		end
		desc_out[prre_pkg::POS_LAST] = req_in.last_in_group; // R9
		desc_out[prre_pkg::POS_STREAM_REPLY] = stream_ok; // R10
		desc_out[prre_pkg::POS_BLOCKED] = stream_ok & req_in.blocked_on_fault_flag; // R11
		desc_out[prre_pkg::POS_RD] = req_in.read_req; // R12
		desc_out[prre_pkg::POS_WR] = req_in.write_req; // R12
		desc_out[prre_pkg::POS_EXEC] = req_in.pasid_present & req_in.read_req
			& req_in.exec_req; // R13
		desc_out[prre_pkg::POS_PRIV] = req_in.pasid_present & has_access
			& req_in.priv_req; // R14
		desc_out[prre_pkg::POS_DATA +: prre_pkg::DATA_W] = req_in.private_data;
	end
endmodule : prre_desc_format

// file: core/prre_event.sv
// Page request queue writer with pending flag and event interrupt
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// R1 - Each record is a 128-bit descriptor with a two-bit type code at bits 1:0.
// R2 - Write descriptor at the tail entry, then advance tail by one.
// R3 - Bus field gets source id upper byte, device/function field the lower byte.
// R4 - PASID-present bit follows the request; PASID field zero when absent.
// R5 - Address field holds page address unless neither read nor write requested.
// R6 - Nine-bit group index reported; zero when neither read nor write requested.
// R7 - Endpoint keeps one outstanding last-in-group per PASID and group index.
// R8 - Endpoint keeps one outstanding last-in-group without PASID per group index.
// R9 - Last-in-group bit marks only the final request of its group.
// R10 - Stream reply bit is written zero when last-in-group is set.
// R11 - Blocked-on-fault bit only with stream reply and not last; else zero.
// R12 - Read and write request bits show the needed permissions.
// R13 - Execute bit only meaningful with PASID present and read requested.
// R14 - Privilege bit 1 supervisor, 0 user, with PASID and read or write.
// R15 - Software answers stream requests and whole groups with responses.
// R16 - Software copies private data into its response.
// R17 - Every descriptor written sets the pending request flag.
// R18 - No new event if the pending flag was already set.
// R19 - Else set held flag; unmasked fires interrupt and clears held.
// R20 - Clearing the mask while held fires the interrupt and clears held.
// R21 - Clearing pending flag while held clears held without interrupt.
// R22 - Descriptor visible and tail advanced before the interrupt goes out.
// R23 - Tail read completes only after accepted descriptors are visible.
// R24 - Status, tail, event reads follow any in-flight interrupt.
// R25 - Descriptor fields use a fixed layout apart from the type code.
module prre_event #(
	parameter int QIDX_W = 8
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic req_valid_in,
	input wire prre_pkg::prre_req_type req_in,
	output logic req_ready_out,
	output logic mem_wr_out,
	output logic [31:0] mem_addr_out,
	output logic [prre_pkg::DESC_W-1:0] mem_data_out,
	input wire logic mem_ack_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic event_intr_out
);
	generate
		if (QIDX_W < 1 || QIDX_W > 24) begin : g_bad_width
			$error("QIDX_W out of range");
		end
	endgenerate

	typedef struct packed {
		prre_pkg::prre_phase_type phase;
		logic ready;
		logic mem_wr;
		logic [31:0] addr;
		logic [prre_pkg::DESC_W-1:0] desc;
		logic [QIDX_W-1:0] tail;
		logic [QIDX_W-1:0] head;
		logic [31:0] base;
		logic pending;
		logic held;
		logic mask;
		logic intr;
		logic [31:0] rdata;
	} prre_state_type;

	prre_state_type s;
	prre_state_type next_s;
	logic [1:0] rst_sync;
	logic rst_n;
	logic [prre_pkg::DESC_W-1:0] fmt_desc;
	logic accept;
	logic done;
	logic new_event;
	logic wr_status;
	logic wr_event;
	logic clear_pending;
	logic mask_eff;
	logic unmask;

	// Reset released through two flops
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'h1};
		end
	end
	assign rst_n = rst_sync[1];

	prre_desc_format u_format (
		.req_in(req_in),
		.desc_out(fmt_desc)
	);

	always_comb begin
		next_s = s;
		next_s.intr = 1'h0;
		next_s.rdata = 32'h0000_0000;
		accept = s.ready & req_valid_in;
		done = (s.phase == prre_pkg::PRRE_WRITE) & mem_ack_in;
		wr_status = reg_wr_in & (reg_addr_in == prre_pkg::REG_STATUS);
		wr_event = reg_wr_in & (reg_addr_in == prre_pkg::REG_EVENT);
		clear_pending = wr_status & reg_wdata_in[prre_pkg::STATUS_PENDING_BIT];
		mask_eff = wr_event ? reg_wdata_in[prre_pkg::EVENT_MASK_BIT] : s.mask;
		unmask = wr_event & s.mask & ~reg_wdata_in[prre_pkg::EVENT_MASK_BIT];
		new_event = done & ~s.pending; // R18

		// Software register writes; hardware updates below take priority
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				prre_pkg::REG_BASE: begin
					next_s.base = reg_wdata_in;
				end
				prre_pkg::REG_HEAD: begin
					next_s.head = reg_wdata_in[QIDX_W-1:0];
				end
				prre_pkg::REG_TAIL: begin
					next_s.tail = reg_wdata_in[QIDX_W-1:0];
				end
				default: begin
				end
			endcase
		end

		unique case (s.phase)
			prre_pkg::PRRE_IDLE: begin
				if (accept) begin
					next_s.phase = prre_pkg::PRRE_WRITE;
					next_s.desc = fmt_desc; // R1
					next_s.mem_wr = 1'h1;
					next_s.addr = s.base + (32'(s.tail) << prre_pkg::ENTRY_SHIFT); // R2
				end
			end
			prre_pkg::PRRE_WRITE: begin
				// Tail moves only once memory reports the write visible
				if (mem_ack_in) begin
					next_s.phase = prre_pkg::PRRE_IDLE;
					next_s.mem_wr = 1'h0;
					next_s.tail = s.tail + 1'b1; // R2 R23
				end
			end
		endcase

		// Set beats a same-cycle write-one-to-clear
		if (done) begin
			next_s.pending = 1'h1; // R17
		end else if (clear_pending) begin
			next_s.pending = 1'h0;
		end

		next_s.mask = mask_eff;
		// A new event's interrupt leaves in the cycle the tail advances, never earlier
		if (new_event) begin
			if (mask_eff) begin
				next_s.held = 1'h1; // R19
			end else begin
				next_s.intr = 1'h1; // R19 R22
				next_s.held = 1'h0;
			end
		end else if (s.held & unmask) begin
			next_s.intr = 1'h1; // R20
			next_s.held = 1'h0;
		end else if (s.held & clear_pending) begin
			next_s.held = 1'h0; // R21
		end

		// One request in flight keeps the full check exact
		next_s.ready = (next_s.phase == prre_pkg::PRRE_IDLE)
			& ((next_s.tail + 1'b1) != next_s.head);

		// Interrupt flop updates no later than the read data, so it is pushed first
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				prre_pkg::REG_BASE: begin
					next_s.rdata = s.base;
				end
				prre_pkg::REG_HEAD: begin
					next_s.rdata = 32'(s.head);
				end
				prre_pkg::REG_TAIL: begin
					next_s.rdata = 32'(s.tail); // R23 R24
				end
				prre_pkg::REG_STATUS: begin
					next_s.rdata[prre_pkg::STATUS_PENDING_BIT] = s.pending; // R24
				end
				prre_pkg::REG_EVENT: begin
					next_s.rdata[prre_pkg::EVENT_MASK_BIT] = s.mask; // R24
					next_s.rdata[prre_pkg::EVENT_HELD_BIT] = s.held;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.mask <= prre_pkg::MASK_RESET;
			s.base <= prre_pkg::BASE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign req_ready_out = s.ready;
	assign mem_wr_out = s.mem_wr;
	assign mem_addr_out = s.addr;
	assign mem_data_out = s.desc;
	assign reg_rdata_out = s.rdata;
	assign event_intr_out = s.intr;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n);

	a_type_code: assert property (mem_wr_out |->
		mem_data_out[1:0] == prre_pkg::TYPE_PAGE_REQ) // R1
		else $error("descriptor type code wrong");
	a_source_split: assert property (accept |=>
		mem_data_out[prre_pkg::POS_BUS +: 8] == $past(req_in.source_id[15:8])
		&& mem_data_out[prre_pkg::POS_DEVFN +: 8] == $past(req_in.source_id[7:0])) // R3
		else $error("source id split wrong");
	a_pasid_clear: assert property (mem_wr_out && !mem_data_out[prre_pkg::POS_PASID_PRESENT]
		|-> mem_data_out[prre_pkg::POS_PASID +: prre_pkg::PASID_W] == '0) // R4
		else $error("pasid not zero when absent");
	a_addr_reserved: assert property (mem_wr_out && !mem_data_out[prre_pkg::POS_RD]
		&& !mem_data_out[prre_pkg::POS_WR] |->
		mem_data_out[prre_pkg::POS_ADDR +: prre_pkg::ADDR_W] == '0
		&& mem_data_out[prre_pkg::POS_GROUP +: prre_pkg::GROUP_W] == '0) // R5
		else $error("reserved address or group not zero");
	a_last_bits: assert property (mem_wr_out && mem_data_out[prre_pkg::POS_LAST] |->
		!mem_data_out[prre_pkg::POS_STREAM_REPLY] && !mem_data_out[prre_pkg::POS_BLOCKED]) // R10 R11
		else $error("stream or blocked bit set on last");
	a_exec_priv: assert property (mem_wr_out |->
		(!mem_data_out[prre_pkg::POS_EXEC] || (mem_data_out[prre_pkg::POS_PASID_PRESENT]
		&& mem_data_out[prre_pkg::POS_RD])) && (!mem_data_out[prre_pkg::POS_PRIV]
		|| mem_data_out[prre_pkg::POS_PASID_PRESENT])) // R13
		else $error("execute or privilege bit invalid");
	a_tail_step: assert property (done && !reg_wr_in |=>
		s.tail == $past(s.tail) + 1'b1 && s.pending) // R2
		else $error("tail or pending not updated");
	a_no_repeat: assert property (done && s.pending && !unmask |=> !event_intr_out) // R18
		else $error("event raised with pending set");
	a_event_fire: assert property (done && !s.pending && !mask_eff |=>
		event_intr_out && !s.held) // R19
		else $error("unmasked event not issued");
	a_unmask_fire: assert property (s.held && unmask && !done |=>
		event_intr_out && !s.held) // R20
		else $error("held event not issued on unmask");
	a_clear_held: assert property (s.held && clear_pending && !unmask && !done |=>
		!s.held && !event_intr_out) // R21
		else $error("held flag not dropped quietly");
	a_intr_cause: assert property (event_intr_out |->
		$past(done) || $past(unmask)) // R22
		else $error("interrupt without cause");
endmodule : prre_event

// file: verif/prre_endpoint_model.sv
// Endpoint and memory model on the far side of the page request block
`timescale 1ns/1ps
module prre_endpoint_model (
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic ready_in,
	input wire logic mem_wr_in,
	output logic valid_out,
	output prre_pkg::prre_req_type req_out,
	output logic mem_ack_out
);
	logic [8:0] next_group = 9'h000;
	int wait_cnt = 0;
	initial begin
		valid_out = 1'h0;
		req_out = '0;
		mem_ack_out = 1'h0;
	end
	task automatic send(input prre_pkg::prre_req_type r, output bit ok);
		ok = 1'h0;
		// Group index never reused while a last request may be outstanding
		if (r.last_in_group) begin
			r.group_index = next_group;
			next_group = next_group + 9'h001;
		end
		@(posedge clk_in);
		valid_out <= 1'h1;
		req_out <= r;
		for (int i = 0; i < 300 && !ok; i++) begin
			@(posedge clk_in);
			ok = ready_in;
		end
		valid_out <= 1'h0;
		req_out <= ~r;
	endtask : send
	always @(posedge clk_in) begin
		if (mem_wr_in && !mem_ack_out) begin
			if (wait_cnt == 0) begin
				mem_ack_out <= 1'h1;
			end else begin
				wait_cnt <= wait_cnt - 1;
			end
		end else begin
			mem_ack_out <= 1'h0;
			wait_cnt <= slow_in ? int'($urandom_range(3, 0)) : 0;
		end
	end
endmodule : prre_endpoint_model

// file: verif/prre_event_bench.sv
// Self-checking bench for the page request event block
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
$display("wrong value at %0t: %s", $time, m); end end
module prre_event_bench;
	localparam int QW = 3;
	localparam int DEPTH = 2 ** QW;
	logic clk_in = 1'h0, reset_n_in = 1'h0, slow = 1'h0, req_valid, ready, mem_wr, mem_ack;
	logic reg_wr = 1'h0, reg_rd = 1'h0, intr;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, base_m = 32'h0;
	logic [127:0] mem_data;
	logic [127:0] exp_q[$];
	prre_pkg::prre_req_type req;
	int n_mismatch = 0, compares = 0, head_m = 0, tail_m = 0;
	bit pend_m, held_m, mask_m = 1, busy_m, exp_intr, run, wr_d, rd_d;
	prre_event #(.QIDX_W(QW)) u_prre_event (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.req_valid_in(req_valid), .req_in(req), .req_ready_out(ready), .mem_wr_out(mem_wr),
		.mem_addr_out(mem_addr), .mem_data_out(mem_data), .mem_ack_in(mem_ack),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .event_intr_out(intr));
	prre_endpoint_model u_prre_endpoint_model (.clk_in(clk_in), .slow_in(slow),
		.ready_in(ready), .mem_wr_in(mem_wr), .valid_out(req_valid), .req_out(req),
		.mem_ack_out(mem_ack));
	initial forever #20 clk_in = ~clk_in;
	function automatic logic [127:0] exp_desc(input prre_pkg::prre_req_type r);
		logic [127:0] d;
		logic rw;
		d = '0;
		rw = r.read_req | r.write_req;
		d[1:0] = prre_pkg::TYPE_PAGE_REQ;
		d[prre_pkg::POS_STREAM_REPLY] = r.stream_reply_wanted & ~r.last_in_group;
		d[prre_pkg::POS_BLOCKED] = r.blocked_on_fault_flag & r.stream_reply_wanted
			& ~r.last_in_group;
		d[prre_pkg::POS_PASID_PRESENT] = r.pasid_present;
		d[prre_pkg::POS_BUS +: 8] = r.source_id[15:8];
		d[prre_pkg::POS_DEVFN +: 8] = r.source_id[7:0];
		if (r.pasid_present) d[prre_pkg::POS_PASID +: 20] = r.pasid;
		d[prre_pkg::POS_RD] = r.read_req;
		d[prre_pkg::POS_WR] = r.write_req;
		d[prre_pkg::POS_LAST] = r.last_in_group;
		d[prre_pkg::POS_PRIV] = r.priv_req & r.pasid_present & rw;
		d[prre_pkg::POS_DATA +: 8] = r.private_data;
		if (rw) d[prre_pkg::POS_GROUP +: 9] = r.group_index;
		d[prre_pkg::POS_EXEC] = r.exec_req & r.pasid_present & r.read_req;
		if (rw) d[prre_pkg::POS_ADDR +: 52] = r.page_addr;
		return d;
	endfunction : exp_desc
	function automatic logic [31:0] exp_reg(input logic [7:0] a);
		case (a)
			prre_pkg::REG_BASE: return base_m;
			prre_pkg::REG_HEAD: return 32'(head_m);
			prre_pkg::REG_TAIL: return 32'(tail_m);
			prre_pkg::REG_STATUS: return {31'h0, pend_m};
			prre_pkg::REG_EVENT: return {mask_m, held_m, 30'h0};
			default: return 32'h0;
		endcase
	endfunction : exp_reg
	always @(posedge clk_in) begin
		bit ack;
		bit fresh;
		bit mask_new;
		ack = mem_wr & mem_ack;
		fresh = ack && !pend_m;
		// A mask written in the landing cycle already governs that event
		mask_new = (reg_wr && reg_addr == prre_pkg::REG_EVENT) ? reg_wdata[31] : mask_m;
		wr_d = reg_wr;
		rd_d = reg_rd;
		exp_intr = 0;
		if (run && req_valid && ready) begin
			exp_q.push_back(exp_desc(req));
			busy_m = 1;
		end
		if (ack) begin
			`CHK(mem_data, exp_q.pop_front(), "descriptor")
			`CHK(mem_addr, base_m + 32'(tail_m * 16), "entry address")
			tail_m = (tail_m + 1) % DEPTH;
			busy_m = 0;
			if (!pend_m) begin
				held_m = mask_new;
				exp_intr = !mask_new;
			end
			pend_m = 1;
		end
		if (reg_wr) begin
			case (reg_addr)
				prre_pkg::REG_BASE: base_m = reg_wdata;
				prre_pkg::REG_HEAD: head_m = int'(reg_wdata % DEPTH);
				prre_pkg::REG_TAIL: if (!ack) tail_m = int'(reg_wdata % DEPTH);
				prre_pkg::REG_STATUS: if (reg_wdata[0]) begin
					// Landing descriptor keeps pending; only a fresh event keeps held
					if (!ack) pend_m = 0;
					if (!fresh) held_m = 0;
				end
				prre_pkg::REG_EVENT: begin
					if (held_m && mask_m && !reg_wdata[31]) {exp_intr, held_m} = 2'h2;
					mask_m = reg_wdata[31];
				end
				default: ;
			endcase
		end
	end
	always @(negedge clk_in) begin
		if (run) begin
			`CHK(intr, exp_intr, "interrupt")
			`CHK(mem_wr, busy_m, "write request")
			if (!wr_d) `CHK(ready, !busy_m && (tail_m + 1) % DEPTH != head_m, "ready")
			if (!rd_d) `CHK(reg_rdata, 32'h0, "idle read data")
		end
	end
	task automatic stop_test();
		if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_in);
		reg_wr <= 1'h0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a);
		@(posedge clk_in);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_in);
		reg_rd <= 1'h0;
		@(negedge clk_in);
		`CHK(reg_rdata, exp_reg(a), "register read")
	endtask : reg_read
	task automatic put();
		logic [127:0] t;
		bit ok;
		t = {$urandom, $urandom, $urandom, $urandom};
		u_prre_endpoint_model.send(t[$bits(req)-1:0], ok);
		if (!ok) begin
			n_mismatch++;
			stop_test();
		end
	endtask : put
	task automatic idle();
		@(posedge clk_in);
		for (int i = 0; i < 50 && busy_m; i++) @(posedge clk_in);
		if (busy_m) begin
			n_mismatch++;
			stop_test();
		end
		@(posedge clk_in);
	endtask : idle
	initial begin
		void'($urandom(98));
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		run = 1;
		for (int a = 0; a <= 20; a += 4) reg_read(8'(a));
		reg_write(prre_pkg::REG_BASE, 32'h0000_4000);
		reg_write(8'h14, 32'hFFFF_FFFF);
		reg_write(prre_pkg::REG_EVENT, 32'hC000_0000);
		// Masked first event is held, then released by unmasking
		put();
		idle();
		for (int a = 8; a <= 20; a += 4) reg_read(8'(a));
		reg_write(prre_pkg::REG_EVENT, 32'h0);
		put();
		idle();
		reg_write(prre_pkg::REG_STATUS, 32'h1);
		put();
		idle();
		reg_write(prre_pkg::REG_EVENT, 32'h8000_0000);
		reg_write(prre_pkg::REG_STATUS, 32'h1);
		put();
		idle();
		reg_read(prre_pkg::REG_EVENT);
		reg_write(prre_pkg::REG_STATUS, 32'h1);
		reg_read(prre_pkg::REG_EVENT);
		// Fill to one short of the head, then stall until software frees space
		slow <= 1'h1;
		for (int i = 0; i < DEPTH && (tail_m + 1) % DEPTH != head_m; i++) begin
			put();
			idle();
		end
		fork
			put();
			begin
				repeat (20) @(posedge clk_in);
				reg_write(prre_pkg::REG_HEAD, 32'(tail_m));
			end
		join
		for (int i = 0; i < 40; i++) begin
			slow <= 1'($urandom);
			// Software has serviced and answered every entry before freeing it
			reg_write(prre_pkg::REG_HEAD, 32'(tail_m));
			if ($urandom_range(1, 0) != 0) reg_write(prre_pkg::REG_STATUS, 32'h1);
			reg_write(prre_pkg::REG_EVENT, {1'($urandom), 31'h0});
			put();
		end
		idle();
		reg_write(prre_pkg::REG_TAIL, 32'h0000_0005);
		for (int a = 0; a <= 16; a += 4) reg_read(8'(a));
		stop_test();
	end
endmodule : prre_event_bench
